// ### logic/dbw_regs.svh
`ifndef DBW_REGS_SVH
`define DBW_REGS_SVH
// =====================================================================
// Register indices (word offsets on the plain register port)
`define DBW_OFF_SSR      8'h10
`define DBW_OFF_SPC      8'h11
`define DBW_OFF_SSP      8'h12
`define DBW_OFF_THSEL    8'h13
`define DBW_OFF_IDXSEL   8'h14
`define DBW_OFF_CAUSE    8'h15
`define DBW_OFF_CDATA    8'h16
`define DBW_OFF_STOP     8'h18
`define DBW_OFF_SCRATCH  8'h20
`define DBW_OFF_CBADDR   8'h30
`define DBW_OFF_CBCTRL   8'h40
`define DBW_OFF_DWA1     8'h50
`define DBW_OFF_DWA2     8'h60
`define DBW_OFF_DWCTRL   8'h70
`define DBW_OFF_RWMASK   8'h80
`define DBW_OFF_RWVAL    8'h90
`define DBW_OFF_RWCTRL   8'h9C
// =====================================================================
// Field positions
`define DBW_CTL_EN       0
`define DBW_CTL_SEL      1
`define DBW_CTL_LOAD     2
`define DBW_CTL_THR_LO   16
`define DBW_CAUSE_IDX_LO 16
`define DBW_CAUSE_THR_LO 8
`define DBW_SSR_BITS     11
// =====================================================================
// Cause codes, reset value and control write mask
`define DBW_CAUSE_NONE   3'h0
`define DBW_CAUSE_HOST   3'h1
`define DBW_CAUSE_DEBUG_CALL_INSTR  3'h2
`define DBW_CAUSE_IBRK   3'h3
`define DBW_CAUSE_DWATCH 3'h4
`define DBW_CAUSE_RWATCH 3'h5
`define DBW_RST_WORD     32'h0000_0000
`define DBW_CTL_WMASK    32'h00FF_0007
`endif

// ### logic/dbw_pkg.sv
package dbw_pkg;
  // Entry cause as seen by the pipeline
  typedef logic [2:0] dbw_cause_t;
endpackage

// ### logic/dbw_unit.sv
`timescale 1ns/1ps
`include "dbw_regs.svh"
module dbw_unit #(
  parameter int NUM_UNITS   = 4,
  parameter int NUM_THREADS = 8
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Debug-software register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Configuration-space scratch port for the external debugger
  input  wire logic [2:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        cfg_wr,
  output logic      [31:0] cfg_rdata,
  // Pipeline: current issue and memory access
  input  wire logic        issue_valid,
  input  wire logic [7:0]  issue_thread,
  input  wire logic [31:0] issue_pc,
  input  wire logic        mem_valid,
  input  wire logic        mem_is_load,
  input  wire logic [7:0]  mem_thread,
  input  wire logic [31:0] mem_addr,
  input  wire logic        res_valid,
  input  wire logic [7:0]  res_thread,
  input  wire logic [31:0] res_id,
  // Pipeline: software-raised entries and context to save
  input  wire logic        host_req,
  input  wire logic        debug_call_instr_req,
  input  wire logic [7:0]  debug_call_instr_thread,
  input  wire logic [31:0] ctx_pc,
  input  wire logic [31:0] ctx_sp,
  input  wire logic [10:0] ctx_status,
  input  wire logic        debug_active,
  // Results to the pipeline
  output logic             debug_enter,
  output dbw_pkg::dbw_cause_t enter_cause,
  output logic      [7:0]  thread_hold,
  output logic      [7:0]  regread_thread,
  output logic      [4:0]  regread_index
);

  // Refuse sizes that the fixed register map cannot serve
  if (NUM_UNITS != 4 || NUM_THREADS != 8) begin : g_size_chk
    $error("dbw_unit supports exactly 4 units and 8 threads");
  end

  // =====================================================================
  // State
  typedef struct packed {
    logic [10:0]      saved_status_word;
    logic [31:0]      saved_program_counter;
    logic [31:0]      saved_stack_pointer;
    logic [7:0]       thsel;
    logic [4:0]       idxsel;
    logic [2:0]       cause;
    logic [1:0]       cidx;
    logic [7:0]       cthr;
    logic [31:0]      cdata;
    logic [7:0]       stop;
    logic [7:0][31:0] scratch;
    logic [3:0][31:0] cbaddr;
    logic [3:0][31:0] cbctrl;
    logic [3:0][31:0] dwa1;
    logic [3:0][31:0] dwa2;
    logic [3:0][31:0] dwctrl;
    logic [3:0][31:0] rwmask;
    logic [3:0][31:0] rwval;
    logic [3:0][31:0] rwctrl;
    logic [31:0]      rdata;
    logic             enter;
    logic [2:0]       ecause;
  } dbw_state_t;

  dbw_state_t st_r;
  dbw_state_t st_nxt;

  // =====================================================================
  // Helpers
  // Per-thread enable test shared by every kind of watch unit
  function automatic logic thr_ok(input logic [31:0] ctl,
                                  input logic [7:0]  thr);
    logic [7:0] en;
    en = ctl[`DBW_CTL_THR_LO +: 8];
    return ctl[`DBW_CTL_EN] && (thr < 8'h08) && en[thr[2:0]];
  endfunction

  // Lowest set bit wins when several units fire together
  function automatic logic [1:0] lowest(input logic [3:0] hit);
    logic [1:0] r;
    r = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (hit[k]) r = 2'(k);
    end
    return r;
  endfunction

  // =====================================================================
  // Condition evaluation
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic pc_eq;
      logic ca;
      logic cb;
      logic rca;
      logic rcb;
      pc_eq = (issue_pc == st_r.cbaddr[i]);
      // Inequality mode lets software step out of a tight loop
      ib_hit[i] = issue_valid && thr_ok(st_r.cbctrl[i], issue_thread) &&
                  (st_r.cbctrl[i][`DBW_CTL_SEL] ? !pc_eq : pc_eq);
      ca = (mem_addr == st_r.dwa1[i]);
      cb = (mem_addr == st_r.dwa2[i]);
      // Stores always qualify; loads only when the load bit is set
      dw_hit[i] = mem_valid && thr_ok(st_r.dwctrl[i], mem_thread) &&
                  (!mem_is_load || st_r.dwctrl[i][`DBW_CTL_LOAD]) &&
                  (st_r.dwctrl[i][`DBW_CTL_SEL] ? (ca | cb)
                                                : (ca & cb));
      rca = ((res_id & st_r.rwmask[i]) ==
             (st_r.rwval[i] & st_r.rwmask[i]));
      // Condition B taken as the complement: identifier outside the match
      rcb = !rca;
      rw_hit[i] = res_valid && thr_ok(st_r.rwctrl[i], res_thread) &&
                  (st_r.rwctrl[i][`DBW_CTL_SEL] ? rcb : rca);
    end
  end

  // =====================================================================
  // Next-state logic
  always_comb begin
    logic [7:0] off;
    logic       trig;
    st_nxt = st_r;
    off    = reg_addr;
    trig   = 1'b0;
    st_nxt.enter  = 1'b0;
    st_nxt.ecause = `DBW_CAUSE_NONE;

    // Register read: data stand one cycle after the strobe
    st_nxt.rdata = `DBW_RST_WORD;
    if (reg_rd) begin
      if (off == `DBW_OFF_SSR)    st_nxt.rdata = {21'h0, st_r.saved_status_word};
      if (off == `DBW_OFF_SPC)    st_nxt.rdata = st_r.saved_program_counter;
      if (off == `DBW_OFF_SSP)    st_nxt.rdata = st_r.saved_stack_pointer;
      if (off == `DBW_OFF_THSEL)  st_nxt.rdata = {24'h0, st_r.thsel};
      if (off == `DBW_OFF_IDXSEL) st_nxt.rdata = {27'h0, st_r.idxsel};
      if (off == `DBW_OFF_CAUSE)
        st_nxt.rdata = {14'h0, st_r.cidx, st_r.cthr, 5'h0, st_r.cause};
      if (off == `DBW_OFF_CDATA)  st_nxt.rdata = st_r.cdata;
      if (off == `DBW_OFF_STOP)   st_nxt.rdata = {24'h0, st_r.stop};
      if (off[7:3] == 5'h04)      st_nxt.rdata = st_r.scratch[off[2:0]];
      if (off[7:2] == 6'h0C)      st_nxt.rdata = st_r.cbaddr[off[1:0]];
      if (off[7:2] == 6'h10)      st_nxt.rdata = st_r.cbctrl[off[1:0]];
      if (off[7:2] == 6'h14)      st_nxt.rdata = st_r.dwa1[off[1:0]];
      if (off[7:2] == 6'h18)      st_nxt.rdata = st_r.dwa2[off[1:0]];
      if (off[7:2] == 6'h1C)      st_nxt.rdata = st_r.dwctrl[off[1:0]];
      if (off[7:2] == 6'h20)      st_nxt.rdata = st_r.rwmask[off[1:0]];
      if (off[7:2] == 6'h24)      st_nxt.rdata = st_r.rwval[off[1:0]];
      if (off[7:2] == 6'h27)      st_nxt.rdata = st_r.rwctrl[off[1:0]];
    end

    // External debugger writes scratch; software writes below win ties
    if (cfg_wr) st_nxt.scratch[cfg_addr] = cfg_wdata;

    // Register writes; unmapped offsets are ignored
    if (reg_wr) begin
      if (off == `DBW_OFF_SSR)    st_nxt.saved_status_word    = reg_wdata[10:0];
      if (off == `DBW_OFF_SPC)    st_nxt.saved_program_counter    = reg_wdata;
      if (off == `DBW_OFF_SSP)    st_nxt.saved_stack_pointer    = reg_wdata;
      if (off == `DBW_OFF_THSEL)  st_nxt.thsel  = reg_wdata[7:0];
      if (off == `DBW_OFF_IDXSEL) st_nxt.idxsel = reg_wdata[4:0];
      if (off == `DBW_OFF_CAUSE) begin
        st_nxt.cause = reg_wdata[2:0];
        st_nxt.cthr  = reg_wdata[15:8];
        st_nxt.cidx  = reg_wdata[17:16];
      end
      if (off == `DBW_OFF_CDATA)  st_nxt.cdata  = reg_wdata;
      if (off == `DBW_OFF_STOP)   st_nxt.stop   = reg_wdata[7:0];
      if (off[7:3] == 5'h04)      st_nxt.scratch[off[2:0]] = reg_wdata;
      if (off[7:2] == 6'h0C)      st_nxt.cbaddr[off[1:0]] = reg_wdata;
      if (off[7:2] == 6'h10)
        st_nxt.cbctrl[off[1:0]] = reg_wdata & (`DBW_CTL_WMASK & 32'hFFFF_FFFB);
      if (off[7:2] == 6'h14)      st_nxt.dwa1[off[1:0]] = reg_wdata;
      if (off[7:2] == 6'h18)      st_nxt.dwa2[off[1:0]] = reg_wdata;
      if (off[7:2] == 6'h1C)
        st_nxt.dwctrl[off[1:0]] = reg_wdata & `DBW_CTL_WMASK;
      if (off[7:2] == 6'h20)      st_nxt.rwmask[off[1:0]] = reg_wdata;
      if (off[7:2] == 6'h24)      st_nxt.rwval[off[1:0]] = reg_wdata;
      if (off[7:2] == 6'h27)
        st_nxt.rwctrl[off[1:0]] = reg_wdata & (`DBW_CTL_WMASK & 32'hFFFF_FFFB);
    end

    // Entry arbitration; no new entry while already in debug mode.
    // Priority: host, debug-call, code, data, resource.
    if (!debug_active) begin
      trig = 1'b1;
      if (host_req) begin
        st_nxt.ecause = `DBW_CAUSE_HOST;
        st_nxt.cthr   = 8'h00;
        st_nxt.cidx   = 2'h0;
      end else if (debug_call_instr_req) begin
        st_nxt.ecause = `DBW_CAUSE_DEBUG_CALL_INSTR;
        st_nxt.cthr   = debug_call_instr_thread;
        st_nxt.cidx   = 2'h0;
      end else if (|ib_hit) begin
        st_nxt.ecause = `DBW_CAUSE_IBRK;
        st_nxt.cthr   = issue_thread;
        st_nxt.cidx   = lowest(ib_hit);
      end else if (|dw_hit) begin
        st_nxt.ecause = `DBW_CAUSE_DWATCH;
        st_nxt.cthr   = mem_thread;
        st_nxt.cidx   = lowest(dw_hit);
        st_nxt.cdata  = mem_addr;
      end else if (|rw_hit) begin
        st_nxt.ecause = `DBW_CAUSE_RWATCH;
        st_nxt.cthr   = res_thread;
        st_nxt.cidx   = lowest(rw_hit);
        st_nxt.cdata  = res_id;
      end else begin
        trig = 1'b0;
      end
      if (trig) begin
        // Capture beats any same-cycle software write
        st_nxt.enter = 1'b1;
        st_nxt.cause = st_nxt.ecause;
        st_nxt.saved_program_counter   = ctx_pc;
        st_nxt.saved_stack_pointer   = ctx_sp;
        st_nxt.saved_status_word   = ctx_status;
      end
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // Outputs
  assign reg_rdata      = st_r.rdata;
  assign cfg_rdata      = st_r.scratch[cfg_addr];
  assign debug_enter    = st_r.enter;
  assign enter_cause    = st_r.ecause;
  // Hold is forced off inside debug mode so the debug code can run
  assign thread_hold    = debug_active ? 8'h00 : st_r.stop;
  assign regread_thread = st_r.thsel;
  assign regread_index  = st_r.idxsel;

  // =====================================================================
  // Checks
  sequence s_ib0;
    issue_valid && !debug_active && !host_req && !debug_call_instr_req && ib_hit[0];
  endsequence

  ibrk_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_ib0 |=> debug_enter && enter_cause == `DBW_CAUSE_IBRK &&
              st_r.cidx == 2'h0 && st_r.saved_program_counter == $past(ctx_pc))
    else $error("code breakpoint 0 did not enter debug");
  host_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    host_req && !debug_active |=> st_r.cthr == 8'h00 &&
                                  st_r.cidx == 2'h0 && st_r.cause == 3'h1)
    else $error("host entry did not clear thread and index");
  dwatch_data_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !debug_active && !host_req && !debug_call_instr_req && !(|ib_hit) && (|dw_hit)
    |=> st_r.cdata == $past(mem_addr) && st_r.cause == 3'h4)
    else $error("data watch address not recorded");
  rwatch_data_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !debug_active && !host_req && !debug_call_instr_req && !(|ib_hit) && !(|dw_hit)
    && (|rw_hit) |=> st_r.cdata == $past(res_id))
    else $error("resource id not recorded");
  ib_noten_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !st_r.cbctrl[0][0] |-> !ib_hit[0])
    else $error("disabled breakpoint fired");
  dw_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mem_is_load && !st_r.dwctrl[1][2] |-> !dw_hit[1])
    else $error("load triggered with load bit clear");
  stop_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == `DBW_OFF_STOP ##1 !debug_active
    |-> thread_hold == $past(reg_wdata[7:0]))
    else $error("stop mask not applied");
  ssr_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_enter |-> st_r.saved_status_word == $past(ctx_status))
    else $error("status not captured on entry");

  // Context words are taken in the same cycle as the status word
  ctx_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_enter |-> st_r.saved_program_counter == $past(ctx_pc) &&
                    st_r.saved_stack_pointer == $past(ctx_sp))
    else $error("pc or stack pointer not captured on entry");

  // Debug-call entries carry the calling thread and a zero index
  debug_call_instr_thread_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_call_instr_req && !host_req && !debug_active |=>
      st_r.cthr == $past(debug_call_instr_thread) && st_r.cidx == 2'h0 &&
      st_r.cause == `DBW_CAUSE_DEBUG_CALL_INSTR)
    else $error("debug call entry fields wrong");

  // Every entry reports a real cause code
  cause_code_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_enter |-> enter_cause != `DBW_CAUSE_NONE)
    else $error("entry pulse without a cause");

  // Triggers while in debug mode are dropped, not queued
  no_reentry_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_active |=> !debug_enter)
    else $error("entry taken while in debug mode");

  // Holds are lifted so that debug code can run on every thread
  hold_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_active |-> thread_hold == 8'h00)
    else $error("thread held inside debug mode");

  // Read data are zero outside the cycle after a read strobe
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == `DBW_RST_WORD)
    else $error("read data present without a read");

  // Debugger port writes land unless software hits the same word
  cfg_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg_wr && !(reg_wr && reg_addr[7:3] == 5'h04 &&
                reg_addr[2:0] == cfg_addr)
    |=> st_r.scratch[$past(cfg_addr)] == $past(cfg_wdata))
    else $error("debugger scratch write lost");

  // Thread 1 never fires code unit 0 while its enable bit (bit 17) is clear
  ib_thread_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !st_r.cbctrl[0][17] && issue_thread == 8'h01 |-> !ib_hit[0])
    else $error("breakpoint fired for a disabled thread");

  // No resource unit fires without a resource access
  rw_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !res_valid |-> rw_hit == 4'h0)
    else $error("resource watch fired without an access");
endmodule

// ### verification/dbw_pipe_model.sv
`timescale 1ns/1ps
// =====================================================================
// Pipeline model: raises triggers, supplies context, tracks debug mode
module dbw_pipe_model (
  // Clock, reset and entry feedback
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        debug_enter,
  // Issue, memory and resource traffic
  output logic             issue_valid,
  output logic      [7:0]  issue_thread,
  output logic      [31:0] issue_pc,
  output logic             mem_valid,
  output logic             mem_is_load,
  output logic      [7:0]  mem_thread,
  output logic      [31:0] mem_addr,
  output logic             res_valid,
  output logic      [7:0]  res_thread,
  output logic      [31:0] res_id,
  // Software entries, context and mode
  output logic             host_req,
  output logic             debug_call_instr_req,
  output logic      [7:0]  debug_call_instr_thread,
  output logic      [31:0] ctx_pc,
  output logic      [31:0] ctx_sp,
  output logic      [10:0] ctx_status,
  output logic             debug_active
);
  logic ret_q;
  // Quiet at time zero; thread, address, id, pc and sp lines carry junk, status and load bit zero
  initial begin
    {issue_valid, mem_valid, res_valid, host_req, debug_call_instr_req} = 5'h0;
    {issue_thread, mem_thread, res_thread, debug_call_instr_thread} = 32'hFFFFFFFF;
    {issue_pc, mem_addr, res_id, ctx_pc, ctx_sp} = {5{32'hA5A5A5A5}};
    {mem_is_load, ctx_status, debug_active, ret_q} = 14'h0;
  end
  // Debug mode set by entry, cleared by a return request
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      debug_active <= 1'b0;
    end else if (debug_enter) begin
      debug_active <= 1'b1;
    end else if (ret_q) begin
      debug_active <= 1'b0;
    end
  end
  // One-cycle trigger: 0 issue, 1 memory, 2 resource, 3 host, 4 call
  task automatic fire(input logic [2:0] k, input logic [7:0] th,
                      input logic [31:0] v, input logic ld);
    @(posedge clk_sys);
    {issue_thread, mem_thread, res_thread, debug_call_instr_thread} <= {4{th}};
    {issue_pc, mem_addr, res_id} <= {3{v}};
    ctx_pc <= v ^ 32'h5A5A0000;
    ctx_sp <= ~v;
    ctx_status <= ~v[10:0];
    mem_is_load <= ld;
    {issue_valid, mem_valid, res_valid} <= {k == 3'h0, k == 3'h1, k == 3'h2};
    {host_req, debug_call_instr_req} <= {k == 3'h3, k == 3'h4};
    @(posedge clk_sys);
    {issue_valid, mem_valid, res_valid, host_req, debug_call_instr_req} <= 5'h0;
    {issue_pc, mem_addr, res_id} <= {3{~v}};
  endtask
  // Return from debug mode
  task automatic leave();
    @(posedge clk_sys);
    ret_q <= 1'b1;
    @(posedge clk_sys);
    ret_q <= 1'b0;
  endtask
endmodule

// ### verification/debug_breakpoint_watch_unit_bench.sv
`timescale 1ns/1ps
// =====================================================================
// Register-level bench for the debug breakpoint and watch unit
module debug_breakpoint_watch_unit_bench;
  logic                clk_sys = 1'b0;
  logic                rst_b = 1'b0;
  logic [7:0]          reg_addr = 8'h00;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [2:0]          cfg_addr = 3'h0;
  logic [31:0]         cfg_wdata = 32'h0;
  logic                cfg_wr = 1'b0;
  logic [31:0]         reg_rdata, cfg_rdata, issue_pc, mem_addr, res_id;
  logic [31:0]         ctx_pc, ctx_sp;
  logic [10:0]         ctx_status;
  logic [7:0]          issue_thread, mem_thread, res_thread, debug_call_instr_thread;
  logic [7:0]          thread_hold, regread_thread;
  logic [4:0]          regread_index;
  logic                issue_valid, mem_valid, mem_is_load, res_valid;
  logic                host_req, debug_call_instr_req, debug_active, debug_enter;
  dbw_pkg::dbw_cause_t enter_cause;
  int                  n_errors = 0;
  int                  num_checks = 0;
  // Writable places, all written with ones; reserved bits read 0
  logic [7:0]  ta [14] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h18, 8'h33,
    8'h43, 8'h53, 8'h63, 8'h73, 8'h83, 8'h93, 8'h9F, 8'h16};
  logic [31:0] te [14] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFF, 32'h1F,
    32'hFF, 32'hFFFFFFFF, 32'h00FF0003, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'h00FF0007, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00FF0003, 32'hFFFFFFFF};

  always #5 clk_sys = ~clk_sys;

  dbw_unit DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata), .issue_valid(issue_valid),
    .issue_thread(issue_thread), .issue_pc(issue_pc),
    .mem_valid(mem_valid), .mem_is_load(mem_is_load),
    .mem_thread(mem_thread), .mem_addr(mem_addr), .res_valid(res_valid),
    .res_thread(res_thread), .res_id(res_id), .host_req(host_req),
    .debug_call_instr_req(debug_call_instr_req), .debug_call_instr_thread(debug_call_instr_thread), .ctx_pc(ctx_pc),
    .ctx_sp(ctx_sp), .ctx_status(ctx_status), .debug_active(debug_active),
    .debug_enter(debug_enter), .enter_cause(enter_cause),
    .thread_hold(thread_hold), .regread_thread(regread_thread),
    .regread_index(regread_index));

  dbw_pipe_model PIPE (.clk_sys(clk_sys), .rst_b(rst_b),
    .debug_enter(debug_enter), .issue_valid(issue_valid),
    .issue_thread(issue_thread), .issue_pc(issue_pc),
    .mem_valid(mem_valid), .mem_is_load(mem_is_load),
    .mem_thread(mem_thread), .mem_addr(mem_addr), .res_valid(res_valid),
    .res_thread(res_thread), .res_id(res_id), .host_req(host_req),
    .debug_call_instr_req(debug_call_instr_req), .debug_call_instr_thread(debug_call_instr_thread), .ctx_pc(ctx_pc),
    .ctx_sp(ctx_sp), .ctx_status(ctx_status), .debug_active(debug_active));

  // =====================================================================
  // Checks and bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Entry pulse is due in the cycle after the trigger
  task automatic ent(input logic en, input logic [2:0] c);
    #1;
    chk({31'h0, debug_enter}, {31'h0, en});
    if (en) chk({29'h0, enter_cause}, {29'h0, c});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    #900000;
    n_errors++;
    end_sim();
  end

  // =====================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(8'h15, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h17, 32'h0);
    for (int i = 0; i < 14; i++) wr(ta[i], 32'hFFFFFFFF);
    for (int i = 0; i < 14; i++) rd(ta[i], te[i]);
    chk({24'h0, regread_thread}, 32'hFF);
    chk({27'h0, regread_index}, 32'h1F);
    chk({24'h0, thread_hold}, 32'hFF);
    for (int i = 0; i < 14; i++) wr(ta[i], 32'h0);
    // Scratch shared by both ports
    wr(8'h23, 32'h11112222);
    @(posedge clk_sys);
    cfg_addr <= 3'h3;
    #1 chk(cfg_rdata, 32'h11112222);
    @(posedge clk_sys);
    {cfg_addr, cfg_wdata, cfg_wr} <= {3'h5, 32'h33334444, 1'b1};
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    rd(8'h25, 32'h33334444);
    // Code breakpoints: thread gating, context capture, lowest index
    wr(8'h32, 32'h1000);
    wr(8'h42, 32'h00020001);
    PIPE.fire(3'h0, 8'h0, 32'h1000, 1'b0); ent(1'b0, 3'h0);
    PIPE.fire(3'h0, 8'h1, 32'h1000, 1'b0); ent(1'b1, 3'h3);
    rd(8'h15, 32'h00020103);
    rd(8'h11, 32'h5A5A1000);
    rd(8'h12, 32'hFFFFEFFF);
    rd(8'h10, 32'h7FF);
    PIPE.fire(3'h3, 8'h0, 32'h0, 1'b0); ent(1'b0, 3'h0);
    PIPE.leave();
    wr(8'h30, 32'h3000);
    wr(8'h40, 32'h00020003);
    PIPE.fire(3'h0, 8'h1, 32'h3000, 1'b0); ent(1'b0, 3'h0);
    PIPE.fire(3'h0, 8'h1, 32'h1000, 1'b0); ent(1'b1, 3'h3);
    rd(8'h15, 32'h00000103);
    PIPE.leave();
    wr(8'h40, 32'h0);
    wr(8'h42, 32'h0);
    // Data watchpoints: load gating, either and both conditions
    wr(8'h51, 32'h4000);
    wr(8'h61, 32'h4800);
    wr(8'h71, 32'h00010003);
    PIPE.fire(3'h1, 8'h0, 32'h4800, 1'b1); ent(1'b0, 3'h0);
    PIPE.fire(3'h1, 8'h0, 32'h4800, 1'b0); ent(1'b1, 3'h4);
    rd(8'h15, 32'h00010004);
    rd(8'h16, 32'h4800);
    PIPE.leave();
    wr(8'h71, 32'h00010001);
    PIPE.fire(3'h1, 8'h0, 32'h4800, 1'b0); ent(1'b0, 3'h0);
    wr(8'h71, 32'h00010005);
    wr(8'h61, 32'h4000);
    PIPE.fire(3'h1, 8'h0, 32'h4000, 1'b1); ent(1'b1, 3'h4);
    PIPE.leave();
    wr(8'h71, 32'h0);
    // Resource watchpoints: masked compare, condition A then B
    wr(8'h83, 32'hFF00);
    wr(8'h93, 32'h1200);
    wr(8'h9F, 32'h00040001);
    PIPE.fire(3'h2, 8'h2, 32'h12AB, 1'b0); ent(1'b1, 3'h5);
    rd(8'h15, 32'h00030205);
    rd(8'h16, 32'h12AB);
    PIPE.leave();
    wr(8'h9F, 32'h00040003);
    PIPE.fire(3'h2, 8'h2, 32'h12AB, 1'b0); ent(1'b0, 3'h0);
    PIPE.fire(3'h2, 8'h2, 32'h13AB, 1'b0); ent(1'b1, 3'h5);
    PIPE.leave();
    wr(8'h9F, 32'h0);
    // Host and call entries, stop mask around debug mode
    wr(8'h18, 32'h05);
    #1 chk({24'h0, thread_hold}, 32'h05);
    PIPE.fire(3'h3, 8'h7, 32'h0, 1'b0); ent(1'b1, 3'h1);
    rd(8'h15, 32'h00000001);
    chk({24'h0, thread_hold}, 32'h0);
    PIPE.leave();
    #1 chk({24'h0, thread_hold}, 32'h05);
    PIPE.fire(3'h4, 8'h5, 32'h0, 1'b0); ent(1'b1, 3'h2);
    rd(8'h15, 32'h00000502);
    PIPE.leave();
    end_sim();
  end
endmodule
